// File: rtl/frpc_pkg.sv
package frpc_pkg;

  // widths
  localparam int unsigned REG_W  = 16;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned FINE_W = 4;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SLOTS  = 2;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL   = 16'h6AC0;
  localparam logic [15:0] IDX_FLAGS  = 16'h6AC1;
  localparam logic [15:0] IDX_CLEAR  = 16'h6AC2;
  localparam logic [15:0] IDX_FORCE  = 16'h6AC3;
  localparam logic [15:0] IDX_COUNT  = 16'h6AC4;
  localparam logic [15:0] IDX_RISE0  = 16'h6AD0;
  localparam logic [15:0] IDX_FALL0  = 16'h6AD2;
  localparam logic [15:0] IDX_RISE1  = 16'h6AD8;
  localparam logic [15:0] IDX_FALL1  = 16'h6ADA;
  localparam logic [1:0]  BYTE_OFS   = 2'h0;

  // reset values and writable masks
  localparam logic [REG_W-1:0] CTRL_RESET  = 16'h0000;
  localparam logic [REG_W-1:0] CTRL_WMASK  = 16'h003F;
  localparam logic [REG_W-1:0] FLAG_MASK   = 16'h0007;
  localparam logic [CNT_W-1:0] CNT_RESET   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX     = 16'hFFFF;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [9:0] rsvd;
    logic       cal_en;
    logic       delta_en;
    logic       hires_en;
    logic       pll_sel;
    logic       fall_ie;
    logic       rise_ie;
  } frpc_ctrl_s;

  typedef struct packed {
    logic [12:0] rsvd;
    logic        ovf;
    logic        fall;
    logic        rise;
  } frpc_flags_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0]        strb;
  } frpc_wreq_s;

endpackage

// File: rtl/frpc_sync.sv
`timescale 1ns/1ps
module frpc_sync #(
  parameter int unsigned W = 1
) (
  // clock, reset, enable
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// File: rtl/frpc_top.sv
`timescale 1ns/1ps
module frpc_top
  import frpc_pkg::*;
(
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // capture inputs (asynchronous)
  input  wire logic              capture_in,
  input  wire logic              eighth_pwm_output_a,
  input  wire logic              secondary_pll_output,
  input  wire logic [FINE_W-1:0] fine_code,
  // same-clock permission level
  input  wire logic              protected_write_permission,
  // interrupt
  output logic                   irq
);

  // synchronised inputs
  logic [FINE_W+2:0] async_in;
  logic [FINE_W+2:0] async_s;
  logic              pin_s;
  logic              pwm_s;
  logic              pll_s;
  logic [FINE_W-1:0] fine_s;

  assign async_in = {fine_code, secondary_pll_output, eighth_pwm_output_a, capture_in};

  frpc_sync #(.W(FINE_W + 3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (async_in),
    .q       (async_s)
  );

  assign pin_s  = async_s[0];
  assign pwm_s  = async_s[1];
  assign pll_s  = async_s[2];
  assign fine_s = async_s[FINE_W+2:3];

  // registers
  frpc_ctrl_s        ctrl_q;
  frpc_flags_s       flags_q;
  frpc_flags_s       flags_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [REG_W-1:0]  rise_q [SLOTS];
  logic [REG_W-1:0]  fall_q [SLOTS];
  logic              slot_q;
  logic              src_prev_q;
  logic              pll_prev_q;

  // axi state
  logic              aw_hold_q;
  logic              w_hold_q;
  frpc_wreq_s        wreq_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [DATA_W-1:0] rdata_q;

  // capture source: calibration routes the pwm channel in place of the pin
  logic src;
  logic rise_ev;
  logic fall_ev;
  logic tick;
  logic wrap;
  logic [REG_W-1:0] cap_val;

  assign src     = ctrl_q.cal_en ? pwm_s : pin_s;
  assign rise_ev = src & ~src_prev_q;
  assign fall_ev = ~src & src_prev_q;
  // counter runs every cycle or on each pll rising edge
  assign tick    = ctrl_q.pll_sel ? (pll_s & ~pll_prev_q) : 1'b1;
  assign wrap    = tick & (cnt_q == CNT_MAX);
  // fine mode: low bits carry the sub-clock phase of the edge
  assign cap_val = ctrl_q.hires_en ?
                   {cnt_q[CNT_W-FINE_W-1:0], fine_s} : cnt_q;

  // delta mode restarts the count at every captured edge
  assign cnt_d = (ctrl_q.delta_en & (rise_ev | fall_ev)) ? CNT_RESET :
                 tick ? CNT_W'(cnt_q + 1'b1) : cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q      <= CNT_RESET;
      src_prev_q <= 1'b0;
      pll_prev_q <= 1'b0;
    end else if (ce) begin
      cnt_q      <= cnt_d;
      src_prev_q <= src;
      pll_prev_q <= pll_s;
    end
  end

  // two-deep buffer; slot advances after the fall of each pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_q <= '{default: '0};
      fall_q <= '{default: '0};
      slot_q <= 1'b0;
    end else if (ce) begin
      if (rise_ev) begin
        rise_q[slot_q] <= cap_val;
      end
      if (fall_ev) begin
        fall_q[slot_q] <= cap_val;
        slot_q         <= ~slot_q;
      end
    end
  end

  // write path: address and data taken in either order, then applied
  logic             aw_take;
  logic             w_take;
  logic             do_write;
  logic [15:0]      widx;
  logic [REG_W-1:0] wval;
  logic [REG_W-1:0] wbmask;
  logic             w_ctrl;
  logic             w_clear;
  logic             w_force;
  logic             w_hit;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign do_write      = aw_hold_q & w_hold_q & ~bvalid_q;
  assign widx          = wreq_q.addr[ADDR_W-1:2];
  assign wbmask        = {{8{wreq_q.strb[1]}}, {8{wreq_q.strb[0]}}};
  assign wval          = wreq_q.data[REG_W-1:0] & wbmask;
  // a misaligned write is refused and must not touch any register
  assign w_ctrl        = do_write & w_hit & (widx == IDX_CTRL);
  assign w_clear       = do_write & w_hit & (widx == IDX_CLEAR);
  assign w_force       = do_write & w_hit & (widx == IDX_FORCE);
  assign w_hit         = (wreq_q.addr[1:0] == BYTE_OFS) &
                         ((widx == IDX_CTRL) | (widx == IDX_CLEAR) |
                          (widx == IDX_FORCE) | (widx == IDX_FLAGS) |
                          (widx == IDX_COUNT) | (widx == IDX_RISE0) |
                          (widx == IDX_FALL0) | (widx == IDX_RISE1) |
                          (widx == IDX_FALL1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      wreq_q    <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_hold_q   <= 1'b1;
        wreq_q.addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q    <= 1'b1;
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // control register; writes without permission are dropped silently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce && w_ctrl && protected_write_permission) begin
      ctrl_q <= (ctrl_q & ~(CTRL_WMASK & wbmask)) | (wval & CTRL_WMASK);
    end
  end

  // flags: hardware set and force win over a clear in the same cycle
  logic [REG_W-1:0] set_v;
  logic [REG_W-1:0] clr_v;
  logic [REG_W-1:0] frc_v;

  assign set_v   = {13'h0000, wrap, fall_ev, rise_ev};
  assign clr_v   = w_clear ? (wval & FLAG_MASK) : '0;
  assign frc_v   = w_force ? (wval & FLAG_MASK) : '0;
  assign flags_d = (flags_q & ~clr_v) | set_v | frc_v;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= flags_d;
    end
  end

  assign irq = (flags_q.rise & ctrl_q.rise_ie) | (flags_q.fall & ctrl_q.fall_ie);

  // read path: one cycle after the address is taken
  logic [15:0]      ridx;
  logic             r_hit;
  logic [REG_W-1:0] r_val;

  assign s_axi_arready = ~rvalid_q;
  assign ridx          = s_axi_araddr[ADDR_W-1:2];
  assign r_hit         = (s_axi_araddr[1:0] == BYTE_OFS) &
                         ((ridx == IDX_CTRL) | (ridx == IDX_FLAGS) |
                          (ridx == IDX_CLEAR) | (ridx == IDX_FORCE) |
                          (ridx == IDX_COUNT) | (ridx == IDX_RISE0) |
                          (ridx == IDX_FALL0) | (ridx == IDX_RISE1) |
                          (ridx == IDX_FALL1));
  // clear and force read as zero
  assign r_val = (ridx == IDX_CTRL)  ? REG_W'(ctrl_q)  :
                 (ridx == IDX_FLAGS) ? REG_W'(flags_q) :
                 (ridx == IDX_COUNT) ? cnt_q           :
                 (ridx == IDX_RISE0) ? rise_q[0]       :
                 (ridx == IDX_FALL0) ? fall_q[0]       :
                 (ridx == IDX_RISE1) ? rise_q[1]       :
                 (ridx == IDX_FALL1) ? fall_q[1]       : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (ce) begin
      if (s_axi_arvalid & ~rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q  <= r_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= r_hit ? {16'h0000, r_val} : '0;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule

// File: test/frpc_properties.sv
`timescale 1ns/1ps
module frpc_properties
  import frpc_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              capture_in,
  input wire logic              eighth_pwm_output_a,
  input wire logic              irq
);
  logic [7:0] chg_q;
  logic       pin_q;
  logic       pwm_q;
  // history of pin and calibration source changes, so an irq rise can be traced to its cause
  always_ff @(posedge aclk) begin
    pin_q <= capture_in;
    pwm_q <= eighth_pwm_output_a;
    chg_q <= {chg_q[6:0], (capture_in != pin_q) | (eighth_pwm_output_a != pwm_q)};
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ctrl_ok;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == {IDX_CTRL, 2'h0}
      |-> ##[1:8] s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("control write not answered okay");
  property p_bad_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("misaligned read not refused");
  property p_rd_wide;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_rd_wide: assert property (p_rd_wide) else $error("upper read bits set");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_irq_rise;
    $rose(irq) |-> $rose(s_axi_bvalid) || (|chg_q);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
endmodule
bind frpc_top frpc_properties u_prop (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .capture_in,
  .eighth_pwm_output_a, .irq);

// File: test/frpc_pulse_src.sv
`timescale 1ns/1ps
module frpc_pulse_src (
  // clock
  input  wire logic aclk,
  // pulse pin
  output logic      pin
);
  initial pin = 1'b0;
  // low time is waited out before the task returns, so the fall is captured before software reads
  task automatic pulse(input int hi, input int lo);
    @(posedge aclk);
    pin <= 1'b1;
    repeat (hi) @(posedge aclk);
    pin <= 1'b0;
    repeat (lo) @(posedge aclk);
  endtask
endmodule

// File: test/frpc_tb_top.sv
`timescale 1ns/1ps
module frpc_tb_top
  import frpc_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, pll = 1'b0, perm = 1'b0;
  logic              pwm8a = 1'b0, irq, pin;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [2:0]        awprot = 3'h0, arprot = 3'h0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = 4'hF, fine = 4'h0;
  logic [1:0]        bresp, rresp, r;
  logic [15:0]       v, w;
  int                err_total = 0, checked = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  frpc_pulse_src P (.aclk(aclk), .pin(pin));
  frpc_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .capture_in(pin),
    .eighth_pwm_output_a(pwm8a), .secondary_pll_output(pll), .fine_code(fine),
    .protected_write_permission(perm), .irq(irq));
  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] a);
    checked++;
    if (a !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, a);
    end
  endtask
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    logic a, b, t;
    awaddr <= {i, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = awready;
      b = wready;
      t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (b) wvalid <= 1'b0;
    end while (!t);
    bready <= 1'b0;
    chk("bresp", RESP_OKAY, r);
  endtask
  task automatic rd(input logic [15:0] i, output logic [15:0] d, input logic [1:0] o = 2'h0);
    logic a, t;
    araddr <= {i, o};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      a = arready;
      t = rvalid;
      d = rdata[15:0];
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end while (!t);
    rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [15:0] i, input logic [15:0] e);
    rd(i, v);
    chk(nm, e, v);
  endtask
  task automatic t_map();
    rd(16'h6AC5, v);
    chk("hole", RESP_SLVERR, r);
    rd(IDX_CTRL, v, 2'h1);
    chk("misalign", RESP_SLVERR, r);
    rc("ctrl", IDX_CTRL, CTRL_RESET);
    rc("flags", IDX_FLAGS, 16'h0);
  endtask
  task automatic t_perm();
    wr(IDX_CTRL, 16'h0003);
    rc("ctrl", IDX_CTRL, 16'h0);
    perm <= 1'b1;
    wr(IDX_CTRL, 16'hFFFF);
    rc("ctrl", IDX_CTRL, CTRL_WMASK);
    wr(IDX_CTRL, 16'h0003);
  endtask
  task automatic t_capture();
    P.pulse(20, 40);
    rc("flags", IDX_FLAGS, 16'h3);
    chk("irq", 1'b1, irq);
    rd(IDX_RISE0, v);
    rd(IDX_FALL0, w);
    chk("width0", 16'd20, w - v);
    wr(IDX_CLEAR, 16'h3);
    rc("flags", IDX_FLAGS, 16'h0);
    chk("irq", 1'b0, irq);
    P.pulse(35, 40);
    rd(IDX_RISE1, v);
    rd(IDX_FALL1, w);
    chk("width1", 16'd35, w - v);
    wr(IDX_CLEAR, 16'h3);
  endtask
  task automatic t_force();
    wr(IDX_CTRL, 16'h0001);
    wr(IDX_FORCE, 16'h2);
    rc("flags", IDX_FLAGS, 16'h2);
    chk("irq", 1'b0, irq);
    wr(IDX_FORCE, 16'h1);
    chk("irq", 1'b1, irq);
    wr(IDX_CLEAR, 16'h0);
    rc("flags", IDX_FLAGS, 16'h3);
    wr(IDX_CLEAR, 16'h3);
    chk("irq", 1'b0, irq);
  endtask
  task automatic t_modes();
    wr(IDX_CTRL, 16'h0013);
    P.pulse(25, 40);
    rd(IDX_FALL0, w);
    chk("delta", 1'b1, w >= 16'd24 && w <= 16'd26);
    wr(IDX_CTRL, 16'h000B);
    fine <= 4'hA;
    P.pulse(20, 40);
    rd(IDX_RISE1, v);
    rd(IDX_FALL1, w);
    chk("fine", 4'hA, v[3:0]);
    chk("finewidth", 16'd320, w - v);
    wr(IDX_CLEAR, 16'h3);
    wr(IDX_CTRL, 16'h0023);
    pwm8a <= 1'b1;
    repeat (12) @(posedge aclk);
    pwm8a <= 1'b0;
    repeat (12) @(posedge aclk);
    rc("calflags", IDX_FLAGS, 16'h3);
    wr(IDX_CLEAR, 16'h3);
  endtask
  task automatic t_pll();
    wr(IDX_CTRL, 16'h0004);
    rd(IDX_COUNT, v);
    repeat (16) begin
      @(posedge aclk);
      pll <= ~pll;
    end
    repeat (6) @(posedge aclk);
    rd(IDX_COUNT, w);
    chk("pllcount", v + 16'd8, w);
  endtask
  // the counter must not move while the clock enable is low
  task automatic t_freeze();
    logic [15:0] d0, x;
    wr(IDX_CTRL, 16'h0003);
    rd(IDX_COUNT, v);
    rd(IDX_COUNT, w);
    d0 = w - v;
    rd(IDX_COUNT, v);
    ce <= 1'b0;
    repeat (10) @(posedge aclk);
    ce <= 1'b1;
    rd(IDX_COUNT, w);
    x = w - v;
    chk("freeze", d0, x);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_map();
    t_perm();
    t_capture();
    t_force();
    t_modes();
    t_pll();
    t_freeze();
    tally_and_finish();
  end
endmodule
